// ===== shared/tsp_pkg.sv
package tsp_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int ADDR_W     = 20;
    localparam int DATA_W     = 16;
    localparam int STAT_W     = 11;
    localparam int COUNT_W    = 16;
    localparam int MEM_DEPTH  = 512;
    localparam int MEM_AW     = 9;
    localparam int FILL_W     = 10;
    localparam int FIFO_DEPTH = 8;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    // Packing puts address at bit 0, data at 20, status at 36
    typedef struct packed {
        logic [STAT_W-1:0] stat;
        logic [DATA_W-1:0] data;
        logic [ADDR_W-1:0] addr;
    } tsp_state_t;

    typedef struct packed {
        logic       branch;
        tsp_state_t state;
    } tsp_sample_t;

    typedef struct packed {
        tsp_state_t value;
        tsp_state_t care;
    } tsp_pat_t;

    typedef enum logic [1:0] {
        CQ_TIME  = 2'h0,
        CQ_STATE = 2'h1,
        CQ_OFF   = 2'h2
    } tsp_cq_t;

    typedef struct packed {
        tsp_pat_t             trig;
        logic [COUNT_W-1:0]   occ;
        logic                 sto_all;
        tsp_pat_t             sto;
        logic                 pre_en;
        tsp_pat_t             pre;
        tsp_cq_t              cq;
        tsp_pat_t             cqp;
    } tsp_cfg_t;

    typedef struct packed {
        logic               prestore;
        logic [COUNT_W-1:0] count;
        tsp_state_t         state;
    } tsp_entry_t;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'h0,
        PH_RUN   = 2'h1,
        PH_FLUSH = 2'h2,
        PH_DONE  = 2'h3
    } tsp_phase_t;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam tsp_cfg_t CFG_RESET = '{
        trig:    '0,
        occ:     16'h0001,
        sto_all: 1'b1,
        sto:     '0,
        pre_en:  1'b0,
        pre:     '0,
        cq:      CQ_TIME,
        cqp:     '0
    };

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Care bit low means don't care
    function automatic logic tsp_match(tsp_state_t s, tsp_pat_t p);
        return ((s ^ p.value) & p.care) == '0;
    endfunction

endpackage

// ===== hw/tsp_fifo.sv
module tsp_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rstn,
    // Fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Drain side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } tsp_fptr_t;

    tsp_fptr_t        r;
    tsp_fptr_t        next_r;
    logic [WIDTH-1:0] slots [DEPTH];
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    assign empty = r.wp == r.rp;
    assign full  = (r.wp[AW] != r.rp[AW])
                && (r.wp[AW-1:0] == r.rp[AW-1:0]);
    assign push  = i_in_valid && !full;
    assign pop   = i_out_ready && !empty;

    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = slots[r.rp[AW-1:0]];

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.wp = r.wp + 1'b1;
        end
        if (pop) begin
            next_r.rp = r.rp + 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Slots carry no reset; only pointers define content
    always_ff @(posedge i_clock) begin
        if (push) begin
            slots[r.wp[AW-1:0]] <= i_in_data;
        end
    end

endmodule

// ===== hw/tsp_store.sv
//
// Function
// - Trigger fires on Nth match, N 1..65535
// - Occurrence count applies to simple trigger
// - After reset every captured state stored
// - Storage qualifier limits normally stored states
// - Trigger state always stored
// - Up to two prestore states precede store
// - Prestore off after reset
// - Only prestore-qualified states enter buffer
// - Prestore entries carry marker, not count
// - Count measured between normal stores only
// - Count off keeps prestore capture working
// - State matching both stored as normal
// - Never-match prestore qualifier disables prestore
// - Memory holds 512 states, read by line
// - State is 47 bits: address, data, status
// - After trigger store until full, then complete
// - Sequencer branch states are also stored
// - Count qualifier selects time after reset
module tsp_store (
    // Clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_rstn,
    // Configuration
    input  wire logic                  i_cfg_load,
    input  wire tsp_pkg::tsp_cfg_t     i_cfg,
    // Trace control
    input  wire logic                  i_start,
    // Captured states
    input  wire logic                  i_sample_valid,
    input  wire tsp_pkg::tsp_sample_t  i_sample,
    output logic                       o_sample_ready,
    // Readout
    input  wire logic [8:0]            i_rd_addr,
    output tsp_pkg::tsp_entry_t        o_rd_data,
    // Status
    output logic                       o_running,
    output logic                       o_triggered,
    output logic                       o_complete,
    output logic [9:0]                 o_stored,
    output logic [15:0]                o_occ_left
);
    import tsp_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        tsp_phase_t          phase;
        tsp_cfg_t            cfg;
        logic [COUNT_W-1:0]  occ;
        logic                trig;
        logic [1:0]          pcnt;
        tsp_entry_t          pre0;
        tsp_entry_t          pre1;
        tsp_entry_t          held;
        logic [COUNT_W-1:0]  cnt;
        logic [FILL_W-1:0]   wcnt;
        logic                we;
        logic [MEM_AW-1:0]   wa;
        tsp_entry_t          wd;
    } tsp_core_t;

    tsp_core_t    r;
    tsp_core_t    next_r;
    tsp_entry_t   mem [MEM_DEPTH];
    tsp_entry_t   rd;

    // ----------------------------------------
    // Input buffer
    // ----------------------------------------
    logic         q_valid;
    logic         q_ready;
    logic [47:0]  q_bits;
    tsp_sample_t  s;

    tsp_fifo #(
        .WIDTH ($bits(tsp_sample_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clock     (i_clock),
        .i_rstn      (i_rstn),
        .i_in_valid  (i_sample_valid),
        .i_in_data   (i_sample),
        .o_in_ready  (o_sample_ready),
        .o_out_valid (q_valid),
        .o_out_data  (q_bits),
        .i_out_ready (q_ready)
    );

    assign s = tsp_sample_t'(q_bits);

    // Flush writes the second and any third entry, so the drain stalls there
    assign q_ready = r.phase != PH_FLUSH;

    // ----------------------------------------
    // Qualifiers
    // ----------------------------------------
    logic        pop;
    logic        live;
    logic        tmatch;
    logic        sto_q;
    logic        fire;
    logic        normal;
    logic        precand;
    logic        cq_hit;
    tsp_entry_t  ent_norm;
    tsp_entry_t  ent_pre;

    assign pop    = q_valid && q_ready;
    assign live   = pop && (r.phase == PH_RUN);
    assign tmatch = tsp_match(s.state, r.cfg.trig);
    // Default configuration stores all states
    assign sto_q  = r.cfg.sto_all
                 || tsp_match(s.state, r.cfg.sto);

    // Fires only once the down-counter has reached one
    assign fire   = live && !r.trig && tmatch
                 && (r.occ == COUNT_W'(1));

    // Trigger and branch states bypass the qualifier
    assign normal = live && (fire || (r.trig
                 && (sto_q || s.branch)));

    // Normal store wins over prestore on the same state
    assign precand = live && r.cfg.pre_en && !normal
                  && tsp_match(s.state, r.cfg.pre);

    assign cq_hit = (r.cfg.cq == CQ_TIME)
                 || ((r.cfg.cq == CQ_STATE) && pop
                 && tsp_match(s.state, r.cfg.cqp));

    always_comb begin
        ent_norm          = '0;
        ent_norm.state    = s.state;
        ent_norm.count    = (r.cfg.cq == CQ_OFF) ? '0 : r.cnt;
        ent_pre           = '0;
        ent_pre.state     = s.state;
        ent_pre.prestore  = 1'b1;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic        do_wr;
    tsp_entry_t  wr_data;

    always_comb begin
        next_r  = r;
        next_r.we = 1'b0;
        do_wr   = 1'b0;
        wr_data = '0;

        // Saturates instead of wrapping on long gaps
        if ((r.phase == PH_RUN || r.phase == PH_FLUSH)
                && cq_hit && (r.cnt != '1)) begin
            next_r.cnt = r.cnt + 1'b1;
        end

        case (r.phase)
            PH_IDLE: begin
                next_r.phase = PH_IDLE;
            end
            PH_RUN: begin
                if (live && !r.trig && tmatch && !fire) begin
                    next_r.occ = r.occ - 1'b1;
                end
                if (fire) begin
                    next_r.trig = 1'b1;
                end
                if (normal) begin
                    // Interval restarts only on a normal store
                    next_r.cnt = '0;
                    do_wr = 1'b1;
                    if (r.pcnt != 2'h0) begin
                        wr_data      = r.pre0;
                        next_r.pre0  = r.pre1;
                        next_r.pcnt  = r.pcnt - 1'b1;
                        next_r.held  = ent_norm;
                        next_r.phase = PH_FLUSH;
                    end else begin
                        wr_data = ent_norm;
                    end
                end else if (precand) begin
                    // Oldest one drops out when both slots are full
                    if (r.pcnt == 2'h2) begin
                        next_r.pre0 = r.pre1;
                        next_r.pre1 = ent_pre;
                    end else if (r.pcnt == 2'h1) begin
                        next_r.pre1 = ent_pre;
                        next_r.pcnt = 2'h2;
                    end else begin
                        next_r.pre0 = ent_pre;
                        next_r.pcnt = 2'h1;
                    end
                end
            end
            PH_FLUSH: begin
                do_wr = 1'b1;
                if (r.pcnt != 2'h0) begin
                    wr_data     = r.pre0;
                    next_r.pre0 = r.pre1;
                    next_r.pcnt = r.pcnt - 1'b1;
                end else begin
                    // Buffer is empty once the held state goes
                    wr_data      = r.held;
                    next_r.phase = PH_RUN;
                end
            end
            PH_DONE: begin
                next_r.phase = PH_DONE;
            end
            default: begin
                next_r.phase = PH_IDLE;
            end
        endcase

        if (do_wr) begin
            next_r.we   = 1'b1;
            next_r.wa   = r.wcnt[MEM_AW-1:0];
            next_r.wd   = wr_data;
            next_r.wcnt = r.wcnt + 1'b1;
            // Pending prestore entries are lost when memory fills
            if (r.wcnt == FILL_W'(MEM_DEPTH - 1)) begin
                next_r.phase = PH_DONE;
                next_r.pcnt  = 2'h0;
            end
        end

        if (i_cfg_load) begin
            next_r.cfg = i_cfg;
        end

        if (i_start) begin
            next_r.phase = PH_RUN;
            next_r.trig  = 1'b0;
            next_r.pcnt  = 2'h0;
            next_r.cnt   = '0;
            next_r.wcnt  = '0;
            // A zero count is treated as one
            next_r.occ   = (r.cfg.occ == '0) ? COUNT_W'(1)
                                             : r.cfg.occ;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            r       <= '0;
            r.phase <= PH_IDLE;
            r.cfg   <= CFG_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // Trace memory
    // ----------------------------------------
    // Plain array, no reset, so it maps onto block RAM
    always_ff @(posedge i_clock) begin
        if (r.we) begin
            mem[r.wa] <= r.wd;
        end
        rd <= mem[i_rd_addr];
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_rd_data   = rd;
    assign o_running   = (r.phase == PH_RUN) || (r.phase == PH_FLUSH);
    assign o_triggered = r.trig;
    assign o_complete  = r.phase == PH_DONE;
    assign o_stored    = r.wcnt;
    assign o_occ_left  = r.occ;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking

    default disable iff (!i_rstn);

    chk_trig_not_early: assert property (
        (r.phase == PH_RUN && !r.trig && r.occ > COUNT_W'(1)
            && !i_start)
        |=> !r.trig
    ) else $error("trigger before count reached one");

    chk_occ_decrement: assert property (
        (live && !r.trig && tmatch && r.occ > COUNT_W'(1)
            && !i_start)
        |=> r.occ == $past(r.occ) - 1'b1
    ) else $error("occurrence count did not step down");

    chk_trig_stored: assert property (
        $rose(r.trig) |-> r.we
    ) else $error("trigger state was not written");

    chk_sto_default: assert property (
        $rose(i_rstn) |-> r.cfg.sto_all
    ) else $error("storage qualifier not all after reset");

    chk_pre_default: assert property (
        $rose(i_rstn) |-> !r.cfg.pre_en && r.cfg.cq == CQ_TIME
    ) else $error("prestore or count mode wrong after reset");

    chk_pre_marker: assert property (
        (r.we && r.wd.prestore) |-> r.wd.count == '0
    ) else $error("prestore entry carries a count");

    chk_both_normal: assert property (
        (normal && r.pcnt == 2'h0 && !i_start)
        |=> r.we && !r.wd.prestore
    ) else $error("normal state written as prestore");

    chk_flush_bound: assert property (
        (r.phase == PH_FLUSH && !i_start)
        |-> ##[1:2] r.phase != PH_FLUSH
    ) else $error("prestore flush did not finish");

    chk_full_done: assert property (
        (r.wcnt == FILL_W'(MEM_DEPTH)) |-> r.phase == PH_DONE
    ) else $error("full memory but trace not complete");

    chk_one_entry: assert property (
        (r.phase == PH_FLUSH) |-> !q_ready
    ) else $error("new state taken during flush");

    chk_count_off: assert property (
        (r.we && $past(r.cfg.cq) == CQ_OFF
            && r.cfg.cq == CQ_OFF)
        |-> r.wd.count == '0
    ) else $error("count tag produced with count off");

    chk_tag_restart: assert property (
        (normal && !i_start) |=> r.cnt == '0
    ) else $error("interval did not restart on store");

endmodule

// ===== bench/tsp_src.sv
module tsp_src (
    // Clock
    input  wire logic          i_clock,
    // Captured states
    input  wire logic          i_ready,
    output logic               o_valid,
    output tsp_pkg::tsp_sample_t o_sample
);
    timeunit 1ns;
    timeprecision 100ps;
    import tsp_pkg::*;

    initial begin
        o_valid  = 1'b0;
        o_sample = '0;
    end

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // Ready read at the falling edge, where it has settled
    task automatic push(input tsp_sample_t s, input int gap, output bit ok);
        int n;
        n = 0;
        o_sample <= s;
        o_valid  <= 1'b1;
        do begin
            @(negedge i_clock);
            n++;
        end while (i_ready !== 1'b1 && n < 50);
        ok = (n < 50);
        @(posedge i_clock);
        if (gap > 0) begin
            o_valid  <= 1'b0;
            o_sample <= ~s;
            repeat (gap) @(posedge i_clock);
        end
    endtask

    // Released bus shows the inverse of its value, which is the last state again after a gap
    task automatic release_bus();
        o_valid  <= 1'b0;
        o_sample <= ~o_sample;
    endtask
endmodule

// ===== bench/tb_top.sv
`define TSP_CHK(nm, ex, got) begin \
    checks++; \
    if ((got) !== (ex)) begin \
        failures++; \
        $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
end

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import tsp_pkg::*;

    logic        i_clock = 1'b0;
    logic        i_rstn = 1'b0;
    logic        i_cfg_load = 1'b0;
    logic        i_start = 1'b0;
    logic [8:0]  i_rd_addr = '0;
    tsp_cfg_t    i_cfg = CFG_RESET;
    logic        sv, ready, running, trig, complete;
    tsp_sample_t smp;
    tsp_entry_t  rd;
    logic [9:0]  stored;
    logic [15:0] occ_left;
    int          failures = 0, checks = 0, rd_idx = 0;
    int          occ, cnt, nst;
    bit          mon_en = 0, cnt_chk = 0, trg;
    tsp_cfg_t    cfg;
    tsp_entry_t  exp_q[$], pre_q[$];

    always #2.5 i_clock = ~i_clock;

    tsp_src i_src (.i_clock(i_clock), .i_ready(ready), .o_valid(sv),
        .o_sample(smp));

    tsp_store i_dut (.i_clock(i_clock), .i_rstn(i_rstn),
        .i_cfg_load(i_cfg_load), .i_cfg(i_cfg), .i_start(i_start),
        .i_sample_valid(sv), .i_sample(smp), .o_sample_ready(ready),
        .i_rd_addr(i_rd_addr), .o_rd_data(rd), .o_running(running),
        .o_triggered(trig), .o_complete(complete), .o_stored(stored),
        .o_occ_left(occ_left));

    // ----------------------------------------
    // Reference model
    // ----------------------------------------
    function automatic bit hit(tsp_state_t s, tsp_pat_t p);
        return ((s ^ p.value) & p.care) == '0;
    endfunction

    task automatic model(tsp_sample_t x);
        tsp_entry_t e;
        bit nrm;
        if (nst >= MEM_DEPTH) return;
        nrm = 0;
        e = '{prestore: 1'b0, count: '0, state: x.state};
        if (!trg) begin
            if (hit(x.state, cfg.trig)) begin
                if (occ == 1) {trg, nrm} = 2'b11;
                else occ--;
            end
        end else begin
            nrm = cfg.sto_all || hit(x.state, cfg.sto) || x.branch;
        end
        if (nrm) begin
            foreach (pre_q[i]) exp_q.push_back(pre_q[i]);
            nst += pre_q.size() + 1;
            if (cfg.cq == CQ_STATE) e.count = 16'(cnt);
            exp_q.push_back(e);
            pre_q.delete();
            cnt = 0;
        end else begin
            if (cfg.pre_en && hit(x.state, cfg.pre)) begin
                e.prestore = 1'b1;
                pre_q.push_back(e);
                if (pre_q.size() > 2) void'(pre_q.pop_front());
            end
            if (hit(x.state, cfg.cqp)) cnt++;
        end
    endtask

    // Kinds: trigger, store, counted, idle, prestore, both, branch
    function automatic tsp_sample_t gen(int k);
        tsp_sample_t s;
        s.branch = (k == 6);
        s.state.stat = 11'($urandom);
        s.state.data = 16'($urandom);
        if (s.state.data[15:8] == 8'hE8) s.state.data[15:8] = 8'h00;
        case (k)
            0: s.state.addr = 20'h0040F;
            1, 5: s.state.addr = {12'h005, 8'($urandom)};
            2: s.state.addr = 20'h00123;
            4: s.state.addr = 20'h00434;
            default: s.state.addr = 20'h00777;
        endcase
        if (k == 4 || k == 5) s.state.data[15:8] = 8'hE8;
        return s;
    endfunction

    // ----------------------------------------
    // Driver tasks
    // ----------------------------------------
    task automatic start_trace(input bit load, input tsp_cfg_t c);
        if (load) begin
            i_cfg      <= c;
            i_cfg_load <= 1'b1;
            @(posedge i_clock);
            i_cfg_load <= 1'b0;
        end
        cfg = load ? c : CFG_RESET;
        mon_en = 0;
        i_start <= 1'b1;
        @(posedge i_clock);
        i_start <= 1'b0;
        @(posedge i_clock);
        {rd_idx, cnt, nst, trg} = '0;
        occ = (cfg.occ == 0) ? 1 : int'(cfg.occ);
        pre_q.delete();
        cnt_chk = (cfg.cq != CQ_TIME);
        mon_en = 1;
        `TSP_CHK("running", 1'b1, running)
        `TSP_CHK("occ_left", 16'(occ), occ_left)
    endtask

    task automatic feed(input int n);
        tsp_sample_t s;
        bit ok;
        int pk[4] = '{0, 2, 3, 4};
        for (int i = 0; i < n; i++) begin
            s = gen(trg ? int'($urandom % 7) : pk[$urandom % 4]);
            model(s);
            i_src.push(s, $urandom % 3, ok);
            if (!ok) begin
                failures++;
                finish_test();
            end
        end
        i_src.release_bus();
        // Let a flush stall drain before the next start
        repeat (4) @(posedge i_clock);
        for (int i = 0; i < 3000 && exp_q.size() > 0; i++)
            @(posedge i_clock);
        if (exp_q.size() > 0) begin
            failures++;
            finish_test();
        end
        `TSP_CHK("stored", 10'(nst), stored)
    endtask

    // ----------------------------------------
    // Monitor
    // ----------------------------------------
    initial begin
        tsp_entry_t e, got;
        forever begin
            @(posedge i_clock);
            #1;
            if (mon_en && rd_idx < int'(stored)) begin
                // Memory write lags the fill count by one edge
                @(posedge i_clock);
                i_rd_addr <= 9'(rd_idx);
                @(posedge i_clock);
                #1;
                got = rd;
                if (exp_q.size() == 0) begin
                    failures++;
                    $display("Error entry expected none seen %h", got);
                end else begin
                    e = exp_q.pop_front();
                    if (!cnt_chk) got.count = e.count;
                    `TSP_CHK("entry", e, got)
                    // Tags also, except when the count qualifier is time
                end
                rd_idx++;
            end
        end
    end

    task automatic finish_test();
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        tsp_cfg_t c;
        bit ok;
        void'($urandom(19));
        repeat (2) @(posedge i_clock);
        i_rstn <= 1'b1;
        @(negedge i_clock);
        `TSP_CHK("stored", 10'h000, stored)
        `TSP_CHK("ready", 1'b1, ready)
        @(posedge i_clock);
        // Power-up config: everything stored, nothing prestored
        start_trace(0, CFG_RESET);
        feed(12);
        c = CFG_RESET;
        c.trig = '{value: 47'h0040F, care: 47'h000FFFFF};
        c.occ = 16'h0003;
        c.sto_all = 1'b0;
        c.sto = '{value: 47'h00500, care: 47'h000FFF00};
        c.pre_en = 1'b1;
        c.pre = '{value: 47'h0E80000000, care: 47'h0FF0000000};
        c.cq = CQ_STATE;
        c.cqp = '{value: 47'h00123, care: 47'h000FFFFF};
        start_trace(1, c);
        feed(80);
        c.cq = CQ_OFF;
        c.occ = 16'h0001;
        start_trace(1, c);
        feed(40);
        c.pre_en = 1'b0;
        start_trace(1, c);
        feed(40);
        // Largest occurrence count only counts down
        c.occ = 16'hFFFF;
        start_trace(1, c);
        i_src.push(gen(0), 1, ok);
        repeat (4) @(posedge i_clock);
        `TSP_CHK("occ_left", 16'hFFFE, occ_left)
        `TSP_CHK("triggered", 1'b0, trig)
        c = CFG_RESET;
        c.cq = CQ_OFF;
        start_trace(1, c);
        feed(515);
        `TSP_CHK("complete", 1'b1, complete)
        `TSP_CHK("running", 1'b0, running)
        // Complete trace keeps draining and drops new states
        for (int n = 0; n < 9; n++) begin
            i_src.push(gen(3), 0, ok);
            @(negedge i_clock);
            `TSP_CHK("ready", 1'b1, ready)
            `TSP_CHK("stored", 10'h200, stored)
            @(posedge i_clock);
        end
        i_src.release_bus();
        repeat (4) @(posedge i_clock);
        `TSP_CHK("complete", 1'b1, complete)
        finish_test();
    end
endmodule
